// >>> hdl/afp_pkg.sv
// Overview of operation
// - The address/fault pin is an input at power-up and turns into a fault output only after reset once the host writes one to bit 0 of control register 0x05.
// - As a fault output the pin is low for overcurrent, undervoltage, overtemperature or overvoltage and high when no fault exists.
// - Bit D1 of status register 0x02 holds a latched copy of the fault pin so a shutdown fault stays visible after it clears.
// - The latched fault bit clears only on a host write over I2C, never because the fault went away.
// - Any overcurrent detector puts the outputs in high impedance, and operation resumes by itself once the fault is gone.
// - An overcurrent on any one bridge pair shuts down all four half-bridges together.
// - Temperature above the trip point puts every half-bridge in high impedance and pulls the fault pin low when it is an output.
// - Thermal shutdown ends by itself once the temperature falls about thirty degrees below the trip point.
// - Power-on reset clears the overload circuit and holds operation until both supply monitors report their thresholds reached.
// - A power-stage undervoltage at once sets every half-bridge to high impedance and drives the fault pin low.
// - On leaving all-channel shutdown the duty cycle ramps from near zero up to the commanded value at the soft-start rate.
// - The address/fault pin is sampled at power-up and after every reset to latch the I2C address, before any fault output use.
package afp_pkg;

    // Clock and soft-start timing; the step time models the timer capacitor charge.
    localparam int CLK_PERIOD_NS   = 50;
    localparam int SS_STEP_TIME_NS = 10000;
    localparam int SS_STEP_CYCLES  = (SS_STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Thermal trip point and hysteresis in degrees Celsius.
    localparam int OT_TRIP_C    = 150;
    localparam int OT_HYST_C    = 30;
    localparam int OT_RELEASE_C = OT_TRIP_C - OT_HYST_C;

    // Register offsets and bit positions seen by the host.
    localparam logic [7:0] CTRL2_OFFSET          = 8'h05;
    localparam int         CTRL2_FAULT_OUT_BIT   = 0;
    localparam logic [7:0] STATUS_OFFSET         = 8'h02;
    localparam int         STATUS_LATCHED_BIT    = 1;
    localparam logic [7:0] STATUS_RESET          = 8'h00;

    // I2C device addresses selected by the sampled pin level.
    localparam logic [7:0] I2C_ADDR_PIN_LOW  = 8'h54;
    localparam logic [7:0] I2C_ADDR_PIN_HIGH = 8'h56;

    // Data path widths.
    localparam int DUTY_W           = 8;
    localparam int TEMP_W           = 8;
    localparam int NUM_HALF_BRIDGES = 4;

    // Protection sequencer states.
    typedef enum logic [1:0] {
        ST_POR  = 2'b00,
        ST_SHUT = 2'b01,
        ST_RAMP = 2'b10,
        ST_RUN  = 2'b11
    } afp_state_t;

endpackage

// >>> hdl/afp_hyst_flag.sv
`timescale 1ns/1ns
`default_nettype none
module afp_hyst_flag #(
    parameter int W       = 8,
    parameter int TRIP    = 150,
    parameter int RELEASE = 120
) (
    input  wire logic         sys_clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] level,
    output logic              flag
);
    logic next_flag;

    // A release point at or above the trip point would let the flag chatter.
    if (RELEASE >= TRIP || TRIP >= (1 << W)) begin : g_bad_param
        $error("afp_hyst_flag: release must lie below trip and trip inside the range");
    end

    // Set above the trip point, clear only at or below the release point.
    always_comb begin
        next_flag = flag;
        if (level > W'(TRIP)) begin
            next_flag = 1'b1;
        end else if (level <= W'(RELEASE)) begin
            next_flag = 1'b0;
        end
    end

    // Flag register.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end
endmodule
`default_nettype wire

// >>> hdl/afp_soft_start.sv
`timescale 1ns/1ns
`default_nettype none
module afp_soft_start #(
    parameter int DW          = 8,
    parameter int STEP_CYCLES = 200
) (
    input  wire logic          sys_clk,
    input  wire logic          arst_n,
    input  wire logic          run,
    output logic [DW-1:0]      limit,
    output logic               done
);
    localparam int CW = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;
    localparam logic [CW-1:0] STEP_LAST = CW'(STEP_CYCLES - 1);

    logic [CW-1:0] step_cnt;
    logic [CW-1:0] next_step_cnt;
    logic [DW-1:0] next_limit;

    if (STEP_CYCLES < 1 || DW < 2) begin : g_bad_param
        $error("afp_soft_start: step count and width must be positive");
    end

    // The limit restarts from zero whenever run drops, so every exit from
    // shutdown sees the full ramp rather than resuming a stale one.
    always_comb begin
        next_step_cnt = step_cnt;
        next_limit    = limit;
        if (!run) begin
            next_step_cnt = '0;
            next_limit    = '0;
        end else if (limit != '1) begin
            if (step_cnt == STEP_LAST) begin
                next_step_cnt = '0;
                next_limit    = limit + 1'b1;
            end else begin
                next_step_cnt = step_cnt + 1'b1;
            end
        end
    end

    // Ramp registers.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            step_cnt <= '0;
            limit    <= '0;
        end else begin
            step_cnt <= next_step_cnt;
            limit    <= next_limit;
        end
    end

    assign done = (limit == '1);
endmodule
`default_nettype wire

// >>> hdl/afp_fault_protection.sv
`timescale 1ns/1ns
`default_nettype none
module afp_fault_protection
    import afp_pkg::*;
#(
    parameter int SS_STEPS = SS_STEP_CYCLES
) (
    input  wire logic                        sys_clk,
    input  wire logic                        arst_n,
    input  wire logic [NUM_HALF_BRIDGES-1:0] overcurrent_fault,
    input  wire logic                        undervoltage_fault,
    input  wire logic                        overvoltage_fault,
    input  wire logic [TEMP_W-1:0]           temperature,
    input  wire logic                        power_stage_supply_ok,
    input  wire logic                        analog_supply_ok,
    input  wire logic                        ctrl_wr,
    input  wire logic [7:0]                  ctrl_wdata,
    input  wire logic                        status_wr,
    input  wire logic                        adr_fault_in,
    input  wire logic [DUTY_W-1:0]           duty_cmd,
    output logic                             adr_fault_out,
    output logic                             adr_fault_oe,
    output logic [7:0]                       i2c_dev_addr,
    output logic                             addr_valid,
    output logic [7:0]                       status_byte,
    output logic                             latched_fault_bit,
    output logic                             fault_out_enable,
    output logic [NUM_HALF_BRIDGES-1:0]      bridge_hiz,
    output logic [DUTY_W-1:0]                duty_out,
    output logic                             overload_circuit
);
    afp_state_t                  state;
    afp_state_t                  next_state;
    logic                        overtemperature_fault;
    logic                        fault_now;
    logic                        supplies_ok;
    logic                        ramp_run;
    logic                        ramp_done;
    logic [DUTY_W-1:0]           ramp_limit;
    logic                        next_addr_valid;
    logic [7:0]                  next_i2c_dev_addr;
    logic                        next_fault_out_enable;
    logic                        next_latched;
    logic                        next_adr_fault_out;
    logic                        next_adr_fault_oe;
    logic [NUM_HALF_BRIDGES-1:0] next_bridge_hiz;
    logic [DUTY_W-1:0]           next_duty_out;
    logic                        next_overload;

    if (SS_STEPS < 1) begin : g_bad_param
        $error("afp_fault_protection: soft-start step count must be positive");
    end

    afp_hyst_flag #(
        .W       (TEMP_W),
        .TRIP    (OT_TRIP_C),
        .RELEASE (OT_RELEASE_C)
    ) u_thermal (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .level   (temperature),
        .flag    (overtemperature_fault)
    );

    afp_soft_start #(
        .DW          (DUTY_W),
        .STEP_CYCLES (SS_STEPS)
    ) u_ramp (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .run     (ramp_run),
        .limit   (ramp_limit),
        .done    (ramp_done)
    );

    // Any shutdown-causing condition, overcurrent from any detector counting once.
    // Overvoltage has no hysteresis of its own here. The monitor that feeds it is
    // expected to filter its input, or the stage restarts on every glitch.
    assign fault_now   = (|overcurrent_fault) | undervoltage_fault | overvoltage_fault | overtemperature_fault;
    assign supplies_ok = power_stage_supply_ok & analog_supply_ok;
    // The ramp follows the next state, so the edge that enters shutdown or the
    // power-on hold already clears the limit. A fault that lasts a single cycle
    // would otherwise resume from a stale limit instead of from zero.
    // ramp restarts at zero
    assign ramp_run    = (next_state == ST_RAMP) || (next_state == ST_RUN);

    // Address capture and fault-output enable. The pin is read on the first
    // edge after reset release; the enable is refused until that has happened
    // so a host write can never turn the pin around before its level is taken.
    always_comb begin
        next_addr_valid       = addr_valid;
        next_i2c_dev_addr     = i2c_dev_addr;
        next_fault_out_enable = fault_out_enable;
        if (!addr_valid) begin
            next_addr_valid   = 1'b1;
            next_i2c_dev_addr = adr_fault_in ? I2C_ADDR_PIN_HIGH : I2C_ADDR_PIN_LOW;
        end
        if (ctrl_wr && addr_valid) begin
            next_fault_out_enable = ctrl_wdata[CTRL2_FAULT_OUT_BIT];
        end
    end

    // Address and enable registers; reset puts the pin back to input.
    // The address resets to the pulled-up value, which matches a floating pin.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_valid       <= 1'b0;
            i2c_dev_addr     <= I2C_ADDR_PIN_HIGH;
            fault_out_enable <= 1'b0;
        end else begin
            addr_valid       <= next_addr_valid;
            i2c_dev_addr     <= next_i2c_dev_addr;
            fault_out_enable <= next_fault_out_enable;
        end
    end

    // Fault pin and latched status. Detection runs whether or not the pin
    // drives, and a fault in the cycle of a host clear keeps the bit set.
    // The pin value is kept current while the driver is off, so the first
    // driven level after an enable write is already the true fault state.
    always_comb begin
        next_adr_fault_out = ~fault_now;
        next_adr_fault_oe  = next_fault_out_enable & next_addr_valid;
        next_latched       = latched_fault_bit;
        if (fault_now) begin
            next_latched = 1'b1;
        end else if (status_wr) begin
            next_latched = 1'b0;
        end
    end

    // Pin and status registers.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            adr_fault_out     <= 1'b1;
            adr_fault_oe      <= 1'b0;
            latched_fault_bit <= 1'b0;
            status_byte       <= STATUS_RESET;
        end else begin
            adr_fault_out     <= next_adr_fault_out;
            adr_fault_oe      <= next_adr_fault_oe;
            latched_fault_bit <= next_latched;
            status_byte       <= STATUS_RESET | (8'(next_latched) << STATUS_LATCHED_BIT);
        end
    end

    // Protection sequencer. Supply loss outranks faults, which outrank the ramp,
    // so a brown-out always falls back to the power-on hold.
    // Shutdown has no dwell time: the stage restarts on the first clean cycle,
    // so a lasting short cycles between shutdown and the start of a ramp.
    always_comb begin
        next_state = state;
        case (state)
            ST_POR: begin
                if (supplies_ok) begin
                    next_state = fault_now ? ST_SHUT : ST_RAMP;
                end
            end
            ST_SHUT: begin
                if (!fault_now) begin
                    next_state = ST_RAMP;
                end
            end
            ST_RAMP: begin
                if (ramp_done) begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
        if (fault_now && state != ST_POR) begin
            next_state = ST_SHUT;
        end
        if (!supplies_ok) begin
            next_state = ST_POR;
        end
    end

    // Output stage drive follows the next state so the bridges react in the
    // same edge that records the fault.
    // A duty command that drops below the ramp limit takes effect at once.
    // Only increases are held back by the soft-start, which keeps the ramp
    // from ever lifting the output above what the host asked for.
    always_comb begin
        next_bridge_hiz = '1;
        next_duty_out   = '0;
        next_overload   = (next_state == ST_SHUT);
        if (next_state == ST_RAMP) begin
            next_bridge_hiz = '0;
            next_duty_out   = (duty_cmd < ramp_limit) ? duty_cmd : ramp_limit;
        end else if (next_state == ST_RUN) begin
            next_bridge_hiz = '0;
            next_duty_out   = duty_cmd;
        end
    end

    // Sequencer and output-stage registers.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state            <= ST_POR;
            bridge_hiz       <= '1;
            duty_out         <= '0;
            overload_circuit <= 1'b0;
        end else begin
            state            <= next_state;
            bridge_hiz       <= next_bridge_hiz;
            duty_out         <= next_duty_out;
            overload_circuit <= next_overload;
        end
    end

    // Checks on the block's outputs and internal registers. They watch registered values, so a
    // check one edge after its cause sees exactly what the pins carry, and
    // reset stops every check that is in flight.
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    localparam int TRIP_C    = OT_TRIP_C;
    localparam int RELEASE_C = OT_RELEASE_C;

    a_pin_needs_latch: assert property (adr_fault_oe |-> addr_valid && fault_out_enable)
        else $error("fault pin driven before address latch or without enable");

    a_pin_low_fault: assert property (fault_now |=> !adr_fault_out)
        else $error("fault pin not low after a fault");

    a_pin_high_clear: assert property (!fault_now |=> adr_fault_out)
        else $error("fault pin not high without a fault");

    a_latch_set: assert property (fault_now |=> latched_fault_bit && status_byte[STATUS_LATCHED_BIT])
        else $error("latched fault bit not set by a fault");

    a_latch_holds: assert property (latched_fault_bit && !status_wr |=> latched_fault_bit)
        else $error("latched fault bit cleared without a host write");

    a_oc_all_hiz: assert property (|overcurrent_fault |=> bridge_hiz == '1 && duty_out == '0)
        else $error("overcurrent did not release all half-bridges");

    a_oc_recover: assert property (state == ST_SHUT && supplies_ok && !fault_now |=> state == ST_RAMP)
        else $error("no automatic recovery after fault removal");

    a_thermal_hiz: assert property (temperature > TEMP_W'(TRIP_C) |-> ##2 bridge_hiz == '1)
        else $error("thermal trip did not release the bridges");

    a_thermal_hyst: assert property (overtemperature_fault && temperature > TEMP_W'(RELEASE_C)
                                     |=> overtemperature_fault)
        else $error("thermal shutdown left above the release point");

    a_por_hold: assert property (!supplies_ok |=> state == ST_POR && bridge_hiz == '1)
        else $error("operation not held while supplies are low");

    a_uv_now: assert property (undervoltage_fault |=> bridge_hiz == '1 && !adr_fault_out)
        else $error("undervoltage did not act on the next edge");

    a_ramp_cap: assert property (next_state == ST_RAMP |=> duty_out <= $past(ramp_limit))
        else $error("duty exceeded the soft-start limit");

    a_addr_stable: assert property (addr_valid |=> $stable(i2c_dev_addr) && addr_valid)
        else $error("device address changed after the latch");

    a_pin_off: assert property (!fault_out_enable |-> !adr_fault_oe)
        else $error("pin driven while the fault output is disabled");

    a_olp_por: assert property (!supplies_ok |=> !overload_circuit)
        else $error("overload circuit not cleared while supplies are low");

    a_addr_first: assert property (!addr_valid |=> addr_valid &&
                                   i2c_dev_addr == ($past(adr_fault_in) ? I2C_ADDR_PIN_HIGH : I2C_ADDR_PIN_LOW))
        else $error("device address not taken from the pin after reset");

    a_enable_refused: assert property (!addr_valid |=> !fault_out_enable)
        else $error("fault output enabled before the address latch");

    a_ramp_zero: assert property (state == ST_POR || state == ST_SHUT |-> ramp_limit == '0)
        else $error("soft-start limit not at zero during shutdown");

    a_ov_shut: assert property (overvoltage_fault |=> bridge_hiz == '1 && !adr_fault_out)
        else $error("overvoltage did not shut the stage and pull the pin low");

    c_thermal_cycle: cover property (overtemperature_fault ##[1:1000] !overtemperature_fault);
    c_addr_low: cover property (!addr_valid ##1 i2c_dev_addr == I2C_ADDR_PIN_LOW);
    c_latch_clear: cover property (latched_fault_bit ##1 status_wr ##1 !latched_fault_bit);
    c_ramp_to_run: cover property (state == ST_RAMP ##1 state == ST_RUN);
    c_pin_fault: cover property (adr_fault_oe && !adr_fault_out);
endmodule
`default_nettype wire

// >>> sim/afp_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module afp_host_model (
    input  wire logic       sys_clk,
    input  wire logic       addr_valid,
    input  wire logic [7:0] status_byte,
    output logic            ctrl_wr,
    output logic [7:0]      ctrl_wdata,
    output logic            status_wr
);
    // Idle bus: no strobes, data shows a pattern rather than stale values.
    initial begin
        ctrl_wr    = 1'b0;
        ctrl_wdata = 8'h5a;
        status_wr  = 1'b0;
    end

    // control after reset: a slow host may wait before writing.
    task automatic write_ctrl(input logic [7:0] v, input int gap);
        int n;
        n = 0;
        while (addr_valid !== 1'b1 && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
        repeat (gap) @(negedge sys_clk);
        ctrl_wr    = 1'b1;
        ctrl_wdata = v;
        @(negedge sys_clk);
        ctrl_wr    = 1'b0;
        ctrl_wdata = ~v;
    endtask

    // host clear: the only way the latched bit may drop.
    task automatic clear_status();
        status_wr = 1'b1;
        @(negedge sys_clk);
        status_wr = 1'b0;
    endtask

    // Status is read as a whole byte, the way the host would see it.
    task automatic read_status(output logic [7:0] v);
        @(negedge sys_clk);
        v = status_byte;
    endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import afp_pkg::*;
    logic       sys_clk = 1'b0;
    logic       arst_n  = 1'b0;
    logic [3:0] overcurrent_fault = 4'h0;
    logic       undervoltage_fault = 1'b0;
    logic       overvoltage_fault  = 1'b0;
    logic [7:0] temperature = 8'h19;
    logic       power_stage_supply_ok = 1'b1;
    logic       analog_supply_ok      = 1'b1;
    logic       pin_pull = 1'b1;
    logic [7:0] duty_cmd = 8'h80;
    logic       ctrl_wr, status_wr, adr_fault_in, adr_fault_out, adr_fault_oe;
    logic       addr_valid, latched_fault_bit, fault_out_enable, overload_circuit;
    logic [7:0] ctrl_wdata, i2c_dev_addr, status_byte, duty_out, rd;
    logic [3:0] bridge_hiz;
    int         n_fail = 0;
    int         n_checks = 0;
    int         cycles = 0;

    // Pin level: the block when it drives, otherwise the board resistor.
    assign adr_fault_in = adr_fault_oe ? adr_fault_out : pin_pull;

    always #25 sys_clk = ~sys_clk;

    afp_fault_protection #(.SS_STEPS(2)) i_dut (
        .sys_clk(sys_clk), .arst_n(arst_n), .overcurrent_fault(overcurrent_fault),
        .undervoltage_fault(undervoltage_fault), .overvoltage_fault(overvoltage_fault),
        .temperature(temperature), .power_stage_supply_ok(power_stage_supply_ok),
        .analog_supply_ok(analog_supply_ok), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
        .status_wr(status_wr), .adr_fault_in(adr_fault_in), .duty_cmd(duty_cmd),
        .adr_fault_out(adr_fault_out), .adr_fault_oe(adr_fault_oe), .i2c_dev_addr(i2c_dev_addr),
        .addr_valid(addr_valid), .status_byte(status_byte), .latched_fault_bit(latched_fault_bit),
        .fault_out_enable(fault_out_enable), .bridge_hiz(bridge_hiz), .duty_out(duty_out),
        .overload_circuit(overload_circuit)
    );

    afp_host_model i_host (
        .sys_clk(sys_clk), .addr_valid(addr_valid), .status_byte(status_byte),
        .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .status_wr(status_wr)
    );

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // The ceiling is more than twenty times the length of the planned sequence.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            close_out();
        end
    end

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic do_reset();
        arst_n = 1'b0;
        cyc(8);
        arst_n = 1'b1;
        cyc(3);
    endtask

    // Fault kinds 0..3 are the current detectors, then undervoltage, overvoltage, heat.
    task automatic set_fault(input int k, input bit on);
        overcurrent_fault  = (on && k < 4) ? (4'h1 << k) : 4'h0;
        undervoltage_fault = on && k == 4;
        overvoltage_fault  = on && k == 5;
        temperature        = (on && k == 6) ? 8'h97 : 8'h19;
    endtask

    initial begin
        cyc(2);
        check("hiz_in_reset", 8'h0f, bridge_hiz);
        check("oe_in_reset", 8'h00, adr_fault_oe);
        do_reset();
        check("addr_high", I2C_ADDR_PIN_HIGH, i2c_dev_addr);
        check("addr_valid", 8'h01, addr_valid);
        check("run_hiz", 8'h00, bridge_hiz);
        $display("test reset done");

        // A fault with the pin function off: detection works, pin stays undriven.
        set_fault(2, 1'b1);
        cyc(3);
        check("oc_hiz", 8'h0f, bridge_hiz);
        check("oc_oe_off", 8'h00, adr_fault_oe);
        check("oc_latched", 8'h01, latched_fault_bit);
        check("olp_shut", 8'h01, overload_circuit);
        set_fault(2, 1'b0);
        cyc(3);
        check("oc_resume", 8'h00, bridge_hiz);
        check("ramp_low", 8'h01, {7'h0, duty_out < 8'h10});
        i_host.read_status(rd);
        check("held_status", 8'h02, rd);
        cyc(600);
        check("ramp_top", 8'h80, duty_out);
        i_host.clear_status();
        check("cleared", 8'h00, status_byte);
        $display("test silent_fault done");

        i_host.write_ctrl(8'h01, 3);
        check("oe_on", 8'h01, adr_fault_oe);
        check("en_on", 8'h01, fault_out_enable);
        check("pin_ok", 8'h01, adr_fault_out);
        for (int k = 0; k < 7; k++) begin
            set_fault(k, 1'b1);
            cyc(3);
            check("pin_fault", 8'h00, adr_fault_out);
            check("pin_level", 8'h00, adr_fault_in);
            check("all_hiz", 8'h0f, bridge_hiz);
            check("duty_off", 8'h00, duty_out);
            set_fault(k, 1'b0);
            cyc(4);
            check("pin_clear", 8'h01, adr_fault_out);
            check("still_latched", 8'h01, latched_fault_bit);
            i_host.clear_status();
            check("latch_cleared", 8'h00, latched_fault_bit);
        end
        $display("test fault_kinds done");

        // Thermal boundary and hysteresis, with a clear refused mid-fault.
        temperature = 8'h96;
        cyc(3);
        check("at_trip", 8'h00, bridge_hiz);
        temperature = 8'h97;
        cyc(3);
        check("over_trip", 8'h0f, bridge_hiz);
        i_host.clear_status();
        check("clear_refused", 8'h01, latched_fault_bit);
        temperature = 8'h82;
        cyc(3);
        check("hyst_hold", 8'h0f, bridge_hiz);
        temperature = 8'h78;
        cyc(4);
        check("hyst_release", 8'h00, bridge_hiz);
        i_host.clear_status();
        $display("test thermal done");

        // Each supply monitor in turn holds the stage off.
        for (int s = 0; s < 2; s++) begin
            power_stage_supply_ok = (s != 0);
            analog_supply_ok      = (s != 1);
            cyc(3);
            check("supply_hold", 8'h0f, bridge_hiz);
            power_stage_supply_ok = 1'b1;
            analog_supply_ok      = 1'b1;
            cyc(4);
            check("supply_run", 8'h00, bridge_hiz);
        end
        $display("test supplies done");

        // Turning the pin function off releases the pin to the pull-up; then on again.
        i_host.write_ctrl(8'h00, 1);
        check("oe_off", 8'h00, adr_fault_oe);
        check("pin_released", 8'h01, adr_fault_in);
        i_host.write_ctrl(8'h01, 1);
        check("en_again", 8'h01, fault_out_enable);
        $display("test pin_off done");

        // A second reset with a pull-down: input again, new address latched.
        pin_pull = 1'b0;
        do_reset();
        check("addr_low", I2C_ADDR_PIN_LOW, i2c_dev_addr);
        check("oe_after_rst", 8'h00, adr_fault_oe);
        check("en_after_rst", 8'h00, fault_out_enable);
        check("olp_cleared", 8'h00, overload_circuit);
        $display("test second_reset done");
        close_out();
    end
endmodule
`default_nettype wire
